// ---- scp_crc16.sv ----
`timescale 1ns/1ps
module scp_crc16 (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic preset_in,
   input wire logic [15:0] preset_val_in,
   input wire logic bit_stb_in,
   input wire logic bit_in,
   // result
   output logic [15:0] crc_out
);
   logic [15:0] crc_r;
   logic fb;

   assign fb = crc_r[15] ^ bit_in;

   // bit-serial update, preset has priority
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         crc_r <= scp_pkg::CRC_ZEROS;
      end else if (preset_in) begin
         crc_r <= preset_val_in;
      end else if (bit_stb_in) begin
         crc_r <= {crc_r[14:0], 1'b0} ^ (fb ? scp_pkg::CRC_POLY : 16'h0000);
      end
   end

   assign crc_out = crc_r;
endmodule : scp_crc16

// ---- scp_host_model.sv ----
`timescale 1ns/1ps
module scp_host_model (
   // clock and read answer
   input wire logic clk_in,
   input wire logic [7:0] data_in,
   // bus drive
   output logic cs_out = 1'b0,
   output logic wr_out = 1'b0,
   output logic rd_out = 1'b0,
   output logic cd_out = 1'b0,
   output logic ab_out = 1'b0,
   output logic [7:0] data_out = 8'h00
);
   // one access: control select, channel pin from ab, strobe for one edge
   task automatic xfer(input logic ab, wr, input logic [7:0] b,
                       output logic [7:0] q);
      @(posedge clk_in) #1;
      {cs_out, cd_out, ab_out, wr_out, rd_out} = {3'h6 | ab, wr, !wr};
      data_out = b;
      @(posedge clk_in) #1;
      q = data_in;
      {cs_out, wr_out, rd_out} = 3'h0;
      data_out = ~b; // released bus shows no stale byte
   endtask : xfer
endmodule : scp_host_model

// ---- scp_pkg.sv ----
package scp_pkg;
   // bus select codes {control/data, channel}
   localparam logic [1:0] SEL_A_DATA = 2'h0;
   localparam logic [1:0] SEL_B_DATA = 2'h1;
   localparam logic [1:0] SEL_A_CTL = 2'h2;
   localparam logic [1:0] SEL_B_CTL = 2'h3;
   // command byte fields
   localparam int PTR_LSB = 0;
   localparam int PTR_MSB = 2;
   localparam int CMD_LSB = 3;
   localparam int CMD_MSB = 5;
   localparam int CRC_LSB = 6;
   localparam int CRC_MSB = 7;
   // write register indices
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_IRQ = 3'h1;
   localparam logic [2:0] REG_RX = 3'h3;
   localparam logic [2:0] REG_MODE = 3'h4;
   localparam logic [2:0] REG_ADDR = 3'h6;
   localparam logic [2:0] REG_FLAG = 3'h7;
   // read register indices
   localparam logic [2:0] RD_PRIMARY = 3'h0;
   localparam logic [2:0] RD_SPECIAL = 3'h1;
   localparam logic [2:0] RD_TXCRC_LO = 3'h5;
   localparam logic [2:0] RD_TXCRC_HI = 3'h6;
   // command codes
   localparam logic [2:0] CMD_NULL = 3'h0;
   localparam logic [2:0] CMD_ABORT = 3'h1;
   localparam logic [2:0] CMD_EXT_RST = 3'h2;
   localparam logic [2:0] CMD_CHRST = 3'h3;
   localparam logic [2:0] CMD_NEXT_RX = 3'h4;
   localparam logic [2:0] CMD_TX_PEND_RST = 3'h5;
   localparam logic [2:0] CMD_ERR_RST = 3'h6;
   localparam logic [2:0] CMD_RETI = 3'h7;
   // crc reset codes
   localparam logic [1:0] CRC_NONE = 2'h0;
   localparam logic [1:0] CRC_RST_RX = 2'h1;
   localparam logic [1:0] CRC_RST_TX = 2'h2;
   localparam logic [1:0] CRC_RST_EOM = 2'h3;
   // interrupt / wait-ready register bits
   localparam int IRQ_EXT_IE = 0;
   localparam int IRQ_TX_IE = 1;
   localparam int IRQ_RXM_LSB = 3;
   localparam int IRQ_RXM_MSB = 4;
   localparam int IRQ_WR_RX = 5;
   localparam int IRQ_WR_EN = 7;
   localparam logic [1:0] RXM_OFF = 2'h0;
   localparam logic [1:0] RXM_FIRST = 2'h1;
   // receiver control bits
   localparam int RX_EN_BIT = 0;
   localparam int RX_ADDR_BIT = 2;
   localparam int RX_HUNT_BIT = 4;
   localparam int RX_AUTO_BIT = 5;
   // mode parameter field
   localparam int MODE_LSB = 4;
   localparam int MODE_MSB = 5;
   localparam logic [1:0] MODE_SDLC = 2'h2;
   // status bit positions
   localparam int PS_RX_AVAIL = 0;
   localparam int PS_INT_PEND = 1;
   localparam int PS_TX_EMPTY = 2;
   localparam int PS_CARRIER = 3;
   localparam int PS_EOM = 6;
   localparam int PS_ABORT = 7;
   localparam int SS_OVERRUN = 5;
   localparam int SS_CRC_ERR = 6;
   localparam int SS_EOF = 7;
   // crc and framing constants
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_ONES = 16'hffff;
   localparam logic [15:0] CRC_ZEROS = 16'h0000;
   localparam logic [15:0] CRC_RESIDUE = 16'h1d0f;
   localparam logic [7:0] GLOBAL_ADDR = 8'hff;
   localparam logic [7:0] TX_IDLE = 8'hff;
   localparam logic [2:0] STUFF_ONES = 3'h5;
   localparam logic [2:0] ABORT_ONES = 3'h7;
   localparam logic [3:0] WIN_FULL = 4'h8;
   localparam logic [2:0] CHAR_LAST = 3'h7;
   localparam logic [3:0] TX_ABORT_LEN = 4'h8;
   localparam logic [2:0] TX_LAST_BIT = 3'h7;
endpackage : scp_pkg

// ---- scp_sdlc_rx.sv ----
`timescale 1ns/1ps
module scp_sdlc_rx (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic enable_in,
   input wire logic hunt_in,
   input wire logic [7:0] flag_pat_in,
   // serial bit stream
   input wire logic bit_stb_in,
   input wire logic bit_in,
   // frame events and data
   output logic flag_out,
   output logic abort_out,
   output logic data_stb_out,
   output logic data_bit_out,
   output logic char_stb_out,
   output logic [7:0] char_out
);
   logic [2:0] ones_r;
   logic [7:0] win_r;
   logic [3:0] fill_r;
   logic [2:0] nbit_r;
   logic [7:0] sh_r;
   logic [7:0] chr_r;
   logic hunt_r, flag_r, dstb_r, dbit_r, cstb_r;
   logic [7:0] win_nxt;
   logic stuffed;

   assign win_nxt = {bit_in, win_r[7:1]};
   assign stuffed = !bit_in && (ones_r == scp_pkg::STUFF_ONES);

   // destuffing, flag window and character assembly
   always_ff @(posedge clk_in) begin
      if (rst_in || !enable_in) begin
         ones_r <= 3'h0;
         win_r <= 8'h00;
         fill_r <= 4'h0;
         nbit_r <= 3'h0;
         sh_r <= 8'h00;
         chr_r <= 8'h00;
         hunt_r <= 1'b1;
         flag_r <= 1'b0;
         dstb_r <= 1'b0;
         dbit_r <= 1'b0;
         cstb_r <= 1'b0;
      end else begin
         flag_r <= 1'b0;
         dstb_r <= 1'b0;
         cstb_r <= 1'b0;
         if (hunt_in) begin
            hunt_r <= 1'b1;
            fill_r <= 4'h0;
         end else if (bit_stb_in) begin
            if (!bit_in) begin
               ones_r <= 3'h0;
            end else if (ones_r != scp_pkg::ABORT_ONES) begin
               ones_r <= ones_r + 3'h1;
            end
            if (bit_in && ones_r >= scp_pkg::ABORT_ONES - 3'h1) begin
               hunt_r <= 1'b1;
               fill_r <= 4'h0;
            end else if (!stuffed) begin
               win_r <= win_nxt;
               if (win_nxt == flag_pat_in) begin
                  flag_r <= 1'b1;
                  hunt_r <= 1'b0;
                  fill_r <= 4'h0;
                  nbit_r <= 3'h0;
               end else if (fill_r != scp_pkg::WIN_FULL) begin
                  fill_r <= fill_r + 4'h1;
               end else if (!hunt_r) begin
                  dstb_r <= 1'b1;
                  dbit_r <= win_r[0];
                  sh_r <= {win_r[0], sh_r[7:1]};
                  nbit_r <= nbit_r + 3'h1;
                  if (nbit_r == scp_pkg::CHAR_LAST) begin
                     cstb_r <= 1'b1;
                     chr_r <= {win_r[0], sh_r[7:1]};
                  end
               end
            end
         end
      end
   end

   assign flag_out = flag_r;
   assign abort_out = (ones_r == scp_pkg::ABORT_ONES);
   assign data_stb_out = dstb_r;
   assign data_bit_out = dbit_r;
   assign char_stb_out = cstb_r;
   assign char_out = chr_r;
endmodule : scp_sdlc_rx

// ---- scp_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - sdlc crc covers every character, no delay
// - crc result ready at closing flag
// - programmed flag opens and closes frames
// - auto enables wait for carrier detect
// - address search matches secondary or global
// - overrun special, carrier/abort external interrupts
// - closing flag: end of frame, drop receive wait/ready
// - seven or more ones flag abort
// - abort end clears bit, interrupts again
// - select pins decode channel and data/command
// - eight registers, pointer byte then data
// - any reset points at command register
// - pointer returns to command after access
// - crc code, command, pointer in one byte
// - eight command codes decoded
// - null command changes nothing
// - send abort emits eight ones, sdlc only
// - external status latched until reset command
// - channel reset; channel a clears priority
// - next character command re-arms first-character mode
// - crc reset codes decoded
// - sdlc crc presets to all ones
// - error reset clears latched errors
module scp_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // host and dma byte bus
   input wire logic cs_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   input wire logic cd_sel_in,
   input wire logic ab_sel_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   // interrupt handshake
   input wire logic int_ack_in,
   output logic int_out,
   // serial lines, bit 0 is channel a
   input wire logic [1:0] rx_bit_in,
   input wire logic [1:0] rx_bit_stb_in,
   input wire logic [1:0] carrier_detect_in,
   input wire logic [1:0] tx_bit_stb_in,
   output logic [1:0] tx_bit_out,
   output logic [1:0] wait_ready_n_out
);
   typedef enum logic [2:0] {
      FR_HUNT = 3'b001,
      FR_ADDR = 3'b010,
      FR_DATA = 3'b100
   } scp_frame_t;

   logic [1:0] bus_sel;
   logic [1:0] pend_w;
   logic [1:0] chrst_w;
   logic reti_a;
   logic [7:0] rd_ctl_w [0:1];
   logic [7:0] rd_dat_w [0:1];
   logic [7:0] data_r;
   logic insvc_r;

   assign bus_sel = {cd_sel_in, ab_sel_in};

   ////////////////////////////////////////////////////////////////////
   // shared bus answer and interrupt line

   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         data_r <= 8'h00;
      end else if (cs_in && rd_stb_in) begin
         unique case (bus_sel)
            scp_pkg::SEL_A_DATA: data_r <= rd_dat_w[0];
            scp_pkg::SEL_B_DATA: data_r <= rd_dat_w[1];
            scp_pkg::SEL_A_CTL: data_r <= rd_ctl_w[0];
            scp_pkg::SEL_B_CTL: data_r <= rd_ctl_w[1];
         endcase
      end
   end
   assign data_out = data_r;

   // in-service latch of the priority logic
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || chrst_w[0] || reti_a) begin
         insvc_r <= 1'b0;
      end else if (int_ack_in) begin
         insvc_r <= 1'b1;
      end
   end

   assign int_out = (|pend_w) && !insvc_r;

   ////////////////////////////////////////////////////////////////////
   // per-channel logic

   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      localparam logic [1:0] SEL_D =
         (ch == 0) ? scp_pkg::SEL_A_DATA : scp_pkg::SEL_B_DATA;
      localparam logic [1:0] SEL_C =
         (ch == 0) ? scp_pkg::SEL_A_CTL : scp_pkg::SEL_B_CTL;

      logic ctl_wr, ctl_rd, dat_wr, dat_rd, cmd_wr, chan_rst, chrst_r;
      logic [7:0] wreg_r [0:7];
      logic [2:0] ptr_r, cmd;
      logic [1:0] crcc, rxm;
      logic sdlc, rx_go, hunt, addr_ok, addr_miss, accept, eof;
      logic flag, abort, dstb, dbit, cstb;
      logic [7:0] chr;
      logic [15:0] rx_crc, tx_crc, crc_pre_val;
      scp_frame_t fr_r, fr_nxt;
      logic [7:0] rbuf_r;
      logic rfull_r, ovr_r, eof_r, crcerr_r, rxpend_r, armed_r, sppend_r;
      logic [1:0] snap_r, live;
      logic extlat_r, extpend_r;
      logic [7:0] tbuf_r, tsh_r;
      logic tfull_r, tpend_r, tout_r, tsend_r, eom_r;
      logic [2:0] tcnt_r;
      logic [3:0] tabort_r;
      logic abort_cmd, tx_crc_stb, wr_stop_r, wr_act;
      logic [7:0] ps, ss;

      // bus decode for this channel
      assign ctl_wr = cs_in && wr_stb_in && (bus_sel == SEL_C);
      assign ctl_rd = cs_in && rd_stb_in && (bus_sel == SEL_C);
      assign dat_wr = cs_in && wr_stb_in && (bus_sel == SEL_D);
      assign dat_rd = cs_in && rd_stb_in && (bus_sel == SEL_D);
      assign cmd_wr = ctl_wr && (ptr_r == scp_pkg::REG_CMD);
      assign cmd = data_in[scp_pkg::CMD_MSB:scp_pkg::CMD_LSB];
      assign crcc = data_in[scp_pkg::CRC_MSB:scp_pkg::CRC_LSB];
      assign chan_rst = sys_rst_in || chrst_r;
      assign chrst_w[ch] = chrst_r;

      if (ch == 0) begin : g_reti
         assign reti_a = cmd_wr && (cmd == scp_pkg::CMD_RETI);
      end

      // channel reset acts one cycle after the command
      always_ff @(posedge clk_in) begin
         if (sys_rst_in) begin
            chrst_r <= 1'b0;
         end else begin
            chrst_r <= cmd_wr && (cmd == scp_pkg::CMD_CHRST);
         end
      end

      // register pointer
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            ptr_r <= scp_pkg::REG_CMD;
         end else if (cmd_wr) begin
            ptr_r <= data_in[scp_pkg::PTR_MSB:scp_pkg::PTR_LSB];
         end else if ((ctl_wr || ctl_rd) && ptr_r != scp_pkg::REG_CMD) begin
            ptr_r <= scp_pkg::REG_CMD;
         end
      end

      // write registers, second byte of a pointed access
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            for (int i = 0; i < 8; i++) begin
               wreg_r[i] <= 8'h00;
            end
         end else if (ctl_wr && ptr_r != scp_pkg::REG_CMD) begin
            wreg_r[ptr_r] <= data_in;
         end
      end

      // mode and receiver control decode
      assign sdlc =
         wreg_r[scp_pkg::REG_MODE][scp_pkg::MODE_MSB:scp_pkg::MODE_LSB] ==
         scp_pkg::MODE_SDLC;
      assign rx_go = wreg_r[scp_pkg::REG_RX][scp_pkg::RX_EN_BIT] &&
                     (!wreg_r[scp_pkg::REG_RX][scp_pkg::RX_AUTO_BIT] ||
                      carrier_detect_in[ch]);
      assign rxm =
         wreg_r[scp_pkg::REG_IRQ][scp_pkg::IRQ_RXM_MSB:scp_pkg::IRQ_RXM_LSB];
      assign addr_ok = !wreg_r[scp_pkg::REG_RX][scp_pkg::RX_ADDR_BIT] ||
                       chr == wreg_r[scp_pkg::REG_ADDR] ||
                       chr == scp_pkg::GLOBAL_ADDR;
      assign addr_miss = (fr_r == FR_ADDR) && cstb && !addr_ok;
      assign hunt = addr_miss || (ctl_wr && ptr_r == scp_pkg::REG_RX &&
                                  data_in[scp_pkg::RX_HUNT_BIT]);
      assign accept = cstb && (fr_r == FR_DATA ||
                               (fr_r == FR_ADDR && addr_ok));
      assign eof = (fr_r == FR_DATA) && flag;

      scp_sdlc_rx u_rx (
         .clk_in(clk_in),
         .rst_in(chan_rst),
         .enable_in(rx_go),
         .hunt_in(hunt),
         .flag_pat_in(wreg_r[scp_pkg::REG_FLAG]),
         .bit_stb_in(rx_bit_stb_in[ch]),
         .bit_in(rx_bit_in[ch]),
         .flag_out(flag),
         .abort_out(abort),
         .data_stb_out(dstb),
         .data_bit_out(dbit),
         .char_stb_out(cstb),
         .char_out(chr)
      );

      // crc preset value depends on mode
      assign crc_pre_val = sdlc ? scp_pkg::CRC_ONES : scp_pkg::CRC_ZEROS;

      // receive checker: flag or command presets, every data bit counts
      scp_crc16 u_rx_crc (
         .clk_in(clk_in),
         .rst_in(chan_rst),
         .preset_in(flag || (cmd_wr && crcc == scp_pkg::CRC_RST_RX)),
         .preset_val_in(crc_pre_val),
         .bit_stb_in(dstb && fr_r != FR_HUNT),
         .bit_in(dbit),
         .crc_out(rx_crc)
      );

      // frame sequencing
      always_comb begin
         fr_nxt = fr_r;
         unique case (fr_r)
            FR_HUNT: if (flag) fr_nxt = FR_ADDR;
            FR_ADDR: if (cstb) fr_nxt = addr_ok ? FR_DATA : FR_HUNT;
            FR_DATA: if (flag) fr_nxt = FR_ADDR;
            default: fr_nxt = FR_HUNT;
         endcase
         if (abort || !rx_go || hunt) fr_nxt = FR_HUNT;
      end

      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            fr_r <= FR_HUNT;
         end else begin
            fr_r <= fr_nxt;
         end
      end

      // receive buffer, a new character wins over the read
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            rbuf_r <= 8'h00;
            rfull_r <= 1'b0;
         end else begin
            if (dat_rd) rfull_r <= 1'b0;
            if (accept) begin
               rbuf_r <= chr;
               rfull_r <= 1'b1;
            end
         end
      end

      // latched error and end-of-frame flags
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            ovr_r <= 1'b0;
            eof_r <= 1'b0;
            crcerr_r <= 1'b0;
         end else begin
            if (cmd_wr && cmd == scp_pkg::CMD_ERR_RST) begin
               ovr_r <= 1'b0;
               eof_r <= 1'b0;
               crcerr_r <= 1'b0;
            end
            if (accept && rfull_r && !dat_rd) ovr_r <= 1'b1;
            if (eof) begin
               eof_r <= 1'b1;
               crcerr_r <= (rx_crc != scp_pkg::CRC_RESIDUE);
            end
         end
      end

      // character and special receive interrupts
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            rxpend_r <= 1'b0;
            armed_r <= 1'b1;
            sppend_r <= 1'b0;
         end else begin
            if (dat_rd) rxpend_r <= 1'b0;
            if (cmd_wr && cmd == scp_pkg::CMD_NEXT_RX) armed_r <= 1'b1;
            if (accept && rxm == scp_pkg::RXM_FIRST && armed_r) begin
               rxpend_r <= 1'b1;
               armed_r <= 1'b0;
            end
            if (accept && rxm[1]) rxpend_r <= 1'b1;
            if (cmd_wr && cmd == scp_pkg::CMD_ERR_RST) sppend_r <= 1'b0;
            if (rxm != scp_pkg::RXM_OFF &&
                (eof || (accept && rfull_r && !dat_rd))) begin
               sppend_r <= 1'b1;
            end
         end
      end

      // external status: snapshot frozen while latched
      assign live = {abort, carrier_detect_in[ch]};

      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            snap_r <= 2'h0;
            extlat_r <= 1'b0;
            extpend_r <= 1'b0;
         end else begin
            if (cmd_wr && cmd == scp_pkg::CMD_EXT_RST) begin
               extlat_r <= 1'b0;
               extpend_r <= 1'b0;
            end
            if (!extlat_r && live != snap_r) begin
               snap_r <= live;
               if (wreg_r[scp_pkg::REG_IRQ][scp_pkg::IRQ_EXT_IE]) begin
                  extlat_r <= 1'b1;
                  extpend_r <= 1'b1;
               end
            end
         end
      end

      // transmitter: flag idle, buffered bytes, abort run
      assign abort_cmd = cmd_wr && cmd == scp_pkg::CMD_ABORT && sdlc;

      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            tbuf_r <= 8'h00;
            tsh_r <= scp_pkg::TX_IDLE;
            tfull_r <= 1'b0;
            tpend_r <= 1'b0;
            tout_r <= 1'b1;
            tsend_r <= 1'b0;
            eom_r <= 1'b0;
            tcnt_r <= 3'h0;
            tabort_r <= 4'h0;
         end else begin
            if (cmd_wr && cmd == scp_pkg::CMD_TX_PEND_RST) tpend_r <= 1'b0;
            if (cmd_wr && crcc == scp_pkg::CRC_RST_EOM) eom_r <= 1'b0;
            if (abort_cmd) begin
               tabort_r <= scp_pkg::TX_ABORT_LEN;
               tcnt_r <= 3'h0;
               tsend_r <= 1'b0;
               tsh_r <= wreg_r[scp_pkg::REG_FLAG];
            end else if (tx_bit_stb_in[ch]) begin
               if (tabort_r != 4'h0) begin
                  tout_r <= 1'b1;
                  tabort_r <= tabort_r - 4'h1;
               end else begin
                  tout_r <= tsh_r[0];
                  tsh_r <= {1'b1, tsh_r[7:1]};
                  tcnt_r <= tcnt_r + 3'h1;
                  if (tcnt_r == scp_pkg::TX_LAST_BIT) begin
                     if (tfull_r) begin
                        tsh_r <= tbuf_r;
                        tfull_r <= 1'b0;
                        tsend_r <= 1'b1;
                        if (wreg_r[scp_pkg::REG_IRQ][scp_pkg::IRQ_TX_IE]) begin
                           tpend_r <= 1'b1;
                        end
                     end else begin
                        tsh_r <= wreg_r[scp_pkg::REG_FLAG];
                        if (tsend_r) eom_r <= 1'b1;
                        tsend_r <= 1'b0;
                     end
                  end
               end
            end
            if (dat_wr) begin
               tbuf_r <= data_in;
               tfull_r <= 1'b1;
            end
         end
      end
      assign tx_bit_out[ch] = tout_r;

      // transmit generator runs over sent data bits
      assign tx_crc_stb = tx_bit_stb_in[ch] && tabort_r == 4'h0 &&
                          tsend_r && !abort_cmd;

      scp_crc16 u_tx_crc (
         .clk_in(clk_in),
         .rst_in(chan_rst),
         .preset_in(cmd_wr && crcc == scp_pkg::CRC_RST_TX),
         .preset_val_in(crc_pre_val),
         .bit_stb_in(tx_crc_stb),
         .bit_in(tsh_r[0]),
         .crc_out(tx_crc)
      );

      // receive wait/ready stops at frame end until reprogrammed
      always_ff @(posedge clk_in) begin
         if (chan_rst) begin
            wr_stop_r <= 1'b0;
         end else if (eof) begin
            wr_stop_r <= 1'b1;
         end else if (ctl_wr && ptr_r == scp_pkg::REG_IRQ) begin
            wr_stop_r <= 1'b0;
         end
      end

      assign wr_act = wreg_r[scp_pkg::REG_IRQ][scp_pkg::IRQ_WR_EN] &&
                      (wreg_r[scp_pkg::REG_IRQ][scp_pkg::IRQ_WR_RX] ?
                       (rfull_r && !wr_stop_r) : !tfull_r);
      assign wait_ready_n_out[ch] = !wr_act;
      assign pend_w[ch] = rxpend_r || sppend_r || extpend_r || tpend_r;

      // read registers
      always_comb begin
         ps = 8'h00;
         ps[scp_pkg::PS_RX_AVAIL] = rfull_r;
         ps[scp_pkg::PS_INT_PEND] = (ch == 0) && (|pend_w);
         ps[scp_pkg::PS_TX_EMPTY] = !tfull_r;
         ps[scp_pkg::PS_CARRIER] = snap_r[0];
         ps[scp_pkg::PS_EOM] = eom_r;
         ps[scp_pkg::PS_ABORT] = snap_r[1];
         ss = 8'h00;
         ss[scp_pkg::SS_OVERRUN] = ovr_r;
         ss[scp_pkg::SS_CRC_ERR] = crcerr_r;
         ss[scp_pkg::SS_EOF] = eof_r;
         unique case (ptr_r)
            scp_pkg::RD_PRIMARY: rd_ctl_w[ch] = ps;
            scp_pkg::RD_SPECIAL: rd_ctl_w[ch] = ss;
            scp_pkg::RD_TXCRC_LO: rd_ctl_w[ch] = tx_crc[7:0];
            scp_pkg::RD_TXCRC_HI: rd_ctl_w[ch] = tx_crc[15:8];
            default: rd_ctl_w[ch] = 8'h00;
         endcase
      end
      assign rd_dat_w[ch] = rbuf_r;
   end
endmodule : scp_top

// ---- scp_top_monitor.sv ----
`timescale 1ns/1ps
module scp_top_monitor (
   // clock, reset and bus
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cs_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   // outputs watched
   input wire logic [7:0] data_out,
   input wire logic int_out,
   input wire logic [1:0] tx_bit_out,
   input wire logic [1:0] wait_ready_n_out
);
   logic wr_seen_r;
   // any host write since reset
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) wr_seen_r <= 1'b0;
      else if (cs_in && wr_stb_in) wr_seen_r <= 1'b1;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_rst_data_zero: assert property ($fell(sys_rst_in) |-> data_out == 8'h00)
      else $error("data not cleared");
   a_rst_int_low: assert property ($fell(sys_rst_in) |-> !int_out)
      else $error("int not cleared");
   a_rst_tx_idle: assert property ($fell(sys_rst_in) |-> tx_bit_out == 2'h3)
      else $error("tx not idle");
   a_rst_wait_off: assert property ($fell(sys_rst_in) |-> &wait_ready_n_out)
      else $error("wait not off");
   a_data_holds: assert property (!(cs_in && rd_stb_in) |=> $stable(data_out))
      else $error("data changed without read");
   a_quiet_no_int: assert property (!wr_seen_r |-> !int_out)
      else $error("int before setup");
   a_quiet_wait_off: assert property (!wr_seen_r |-> &wait_ready_n_out)
      else $error("wait before setup");
   a_quiet_tx_ones: assert property (!wr_seen_r |-> &tx_bit_out)
      else $error("tx not idle ones");
   // main traffic seen
   c_read: cover property (cs_in && rd_stb_in);
   c_write: cover property ($rose(wr_seen_r));
   c_rst_again: cover property ($fell(sys_rst_in) && $past(wr_seen_r, 2));
   c_int_raise: cover property ($rose(int_out));
endmodule : scp_top_monitor

// ---- scp_top_tb.sv ----
`timescale 1ns/1ps
module scp_top_tb;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, cs, wr, rd, cd, ab, int_out;
   logic [7:0] din, dout, q;
   logic [1:0] tx_stb = 2'h0, tx_out, wrn;
   logic [1:0] rx_stb = 2'h0, rx_bit = 2'h0;
   logic [7:0] setup [4] = '{8'h01, 8'h01, 8'h03, 8'h01};
   int ptrs [4] = '{2, 3, 4, 7}, cmds [5] = '{2, 4, 5, 6, 7};
   int num_errors = 0, checked = 0, cyc = 0, seed;
   initial forever #12.5 clk_in = ~clk_in;
   scp_host_model host (.clk_in(clk_in), .data_in(dout), .cs_out(cs),
      .wr_out(wr), .rd_out(rd), .cd_out(cd), .ab_out(ab), .data_out(din));
   scp_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_in(cs),
      .wr_stb_in(wr), .rd_stb_in(rd), .cd_sel_in(cd), .ab_sel_in(ab),
      .data_in(din), .data_out(dout), .int_ack_in(1'b0), .int_out(int_out),
      .rx_bit_in(rx_bit), .rx_bit_stb_in(rx_stb), .carrier_detect_in(2'h0),
      .tx_bit_stb_in(tx_stb), .tx_bit_out(tx_out), .wait_ready_n_out(wrn));
   task automatic cmp(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   // command byte then status read, against the expected value
   task automatic cmd_rd(input logic c, input logic [7:0] b, exp);
      host.xfer(c, 1'b1, b, q);
      host.xfer(c, 1'b0, 8'h00, q);
      cmp(q, exp);
   endtask : cmd_rd
   // transmit bits at random spacing, all ones expected
   task automatic tx_ones(input int c, n);
      repeat (n) begin
         repeat ($urandom % 3) @(posedge clk_in);
         @(posedge clk_in) #1 tx_stb[c] = 1'b1;
         @(posedge clk_in) #1 tx_stb[c] = 1'b0;
         cmp({7'h00, tx_out[c]}, 8'h01);
      end
   endtask : tx_ones
   // receive line bits, one strobe each
   task automatic rx_bits(input int c, n, input logic b);
      repeat (n) begin
         @(posedge clk_in) #1 {rx_stb[c], rx_bit[c]} = {1'b1, b};
         @(posedge clk_in) #1 rx_stb[c] = 1'b0;
      end
   endtask : rx_bits
   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 4000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      seed = $urandom(32'h4ef4);
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      for (int c = 0; c < 2; c++) begin
         cmd_rd(c[0], 8'h85, 8'h00);
         cmd_rd(c[0], 8'h06, 8'h00);
         foreach (ptrs[i]) cmd_rd(c[0], 8'(ptrs[i]), 8'h00);
         host.xfer(c[0], 1'b1, 8'h04, q);
         host.xfer(c[0], 1'b1, 8'h20, q);
         cmd_rd(c[0], 8'h85, 8'hff);
         foreach (cmds[i]) cmd_rd(c[0], 8'(cmds[i] * 8 + 6), 8'hff);
         host.xfer(c[0], 1'b1, 8'h00, q);
         tx_ones(c, 5);
         host.xfer(c[0], 1'b1, 8'h08, q);
         tx_ones(c, 8);
         host.xfer(c[0], 1'b1, 8'h18, q);
         repeat (4) @(posedge clk_in);
         cmd_rd(c[0], 8'h85, 8'h00);
         // ext interrupt on, receiver on, then a run of ones
         foreach (setup[i]) host.xfer(c[0], 1'b1, setup[i], q);
         rx_bits(c, 7 + $urandom % 3, 1'b1);
         cmd_rd(c[0], 8'h00, (c == 0) ? 8'h86 : 8'h84);
         cmp({7'h00, int_out}, 8'h01);
         rx_bits(c, 1, 1'b0);
         cmd_rd(c[0], 8'h00, (c == 0) ? 8'h86 : 8'h84);
         cmd_rd(c[0], 8'h10, (c == 0) ? 8'h06 : 8'h04);
         host.xfer(c[0], 1'b1, 8'h10, q);
         cmp({7'h00, int_out}, 8'h00);
      end
      // pointer left off command, then a mid-run reset
      host.xfer(1'b0, 1'b1, 8'h05, q);
      @(posedge clk_in) #1 sys_rst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      cmd_rd(1'b0, 8'h06, 8'h00);
      end_of_test();
   end
endmodule : scp_top_tb
bind scp_top scp_top_monitor mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .cs_in(cs_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
   .data_out(data_out), .int_out(int_out), .tx_bit_out(tx_bit_out),
   .wait_ready_n_out(wait_ready_n_out));
